// ### design/supply_and_thermal_protection.sv
// How it works
// - Two undervoltage comparators, higher and lower, each govern different supply groups.
// - Below the higher threshold all step-down converters are switched off.
// - Supply-good goes high once supply is above the higher threshold.
// - Between both thresholds the always-on regulators stay on, control keeps running.
// - Below the lower threshold regulators go off and control is disabled.
// - On recovery above the lower threshold control is reset, then restarted.
// - Die temperature above threshold stops device operation.
// - Operation resumes automatically once die temperature falls back.
// - Overtemperature release uses a lower hysteresis threshold to avoid toggling.
module supply_and_thermal_protection
  import protect_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  input  wire protect_pkg::cmp_s cmp_in,
  output protect_pkg::pwr_s      pwr_out
);
  import protect_pkg::*;

  logic [CMP_W-1:0] sync1_reg;
  logic [CMP_W-1:0] sync1_next;
  logic [CMP_W-1:0] sync2_reg;
  logic [CMP_W-1:0] sync2_next;
  cmp_s             cmp;

  // First stage feeds only the second stage; a metastable level must not fan out
  for (genvar i = 0; i < CMP_W; i++) begin : g_sync
    always_comb begin
      sync1_next[i] = cmp_in[i];
      sync2_next[i] = sync1_reg[i];
    end
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        sync1_reg[i] <= CMP_RST[i];
        sync2_reg[i] <= CMP_RST[i];
      end else if (clk_en) begin
        sync1_reg[i] <= sync1_next[i];
        sync2_reg[i] <= sync2_next[i];
      end
    end
  end

  assign cmp = cmp_s'(sync2_reg);

  seq_state_e           state_reg;
  seq_state_e           state_next;
  logic [RST_CNT_W-1:0] cnt_reg;
  logic [RST_CNT_W-1:0] cnt_next;
  pwr_s                 pwr_reg;
  pwr_s                 pwr_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_OFF: begin
        if (!cmp.sys_below_low) begin
          state_next = ST_CTRL_RESET;
          cnt_next   = RST_CNT_ZERO;
        end
      end
      ST_CTRL_RESET: begin
        if (cmp.sys_below_low) begin
          state_next = ST_OFF;
        end else if (cnt_reg == RST_CNT_LAST) begin
          state_next = ST_LOW_SUPPLY;
        end else begin
          cnt_next = cnt_reg + RST_CNT_W'(1);
        end
      end
      ST_LOW_SUPPLY, ST_RUN, ST_OVERTEMP: begin
        if (cmp.sys_below_low) begin
          state_next = ST_OFF;
        end else if (cmp.temp_over) begin
          state_next = ST_OVERTEMP;
        end else if (state_reg == ST_OVERTEMP && !cmp.temp_clear) begin
          // Stay stopped until the lower release level is crossed
          state_next = ST_OVERTEMP;
        end else if (cmp.sys_below_high) begin
          state_next = ST_LOW_SUPPLY;
        end else begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // Outputs except supply-good decoded from the next state so each one is a plain flip-flop
  always_comb begin
    pwr_next                    = PWR_RST;
    pwr_next.ldo_en             = (state_next != ST_OFF);
    pwr_next.dcdc_en            = (state_next == ST_RUN);
    pwr_next.ctrl_en            = (state_next == ST_LOW_SUPPLY) ||
                                  (state_next == ST_RUN);
    pwr_next.ctrl_rst_n         = (state_next != ST_OFF) &&
                                  (state_next != ST_CTRL_RESET);
    // Supply-good follows the comparator, independent of temperature
    pwr_next.system_supply_good = !cmp.sys_below_high && !cmp.sys_below_low;
    pwr_next.operating          = (state_next == ST_RUN);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_OFF;
      cnt_reg   <= RST_CNT_ZERO;
      pwr_reg   <= PWR_RST;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pwr_reg   <= pwr_next;
    end
  end

  assign pwr_out = pwr_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sync_two_stage_a: assert property (
    $past(clk_en, 1) && $past(clk_en, 2) && $past(nrst, 2)
    |-> sync2_reg == $past(cmp_in, 2))
    else $error("Synchroniser latency is not two enabled cycles");

  high_uv_dcdc_a: assert property (
    clk_en && cmp.sys_below_high |=> !pwr_out.dcdc_en)
    else $error("Converters left on below the higher threshold");

  supply_good_a: assert property (
    clk_en |=> pwr_out.system_supply_good ==
               !($past(cmp.sys_below_high) || $past(cmp.sys_below_low)))
    else $error("Supply-good does not follow the higher threshold");

  ldo_keep_a: assert property (
    clk_en && !cmp.sys_below_low |=> pwr_out.ldo_en)
    else $error("Regulators off while supply above lower threshold");

  low_uv_off_a: assert property (
    clk_en && cmp.sys_below_low |=> !pwr_out.ldo_en && !pwr_out.ctrl_en && !pwr_out.ctrl_rst_n)
    else $error("Regulators or control left on below lower threshold");

  ctrl_restart_a: assert property (
    state_reg == ST_OFF && clk_en && !cmp.sys_below_low
    |=> !pwr_out.ctrl_rst_n && pwr_out.ldo_en
    && state_reg == ST_CTRL_RESET && cnt_reg == RST_CNT_ZERO)
    else $error("Control not reset on supply recovery");

  ctrl_release_a: assert property (
    state_reg == ST_CTRL_RESET && cnt_reg == RST_CNT_LAST && clk_en && !cmp.sys_below_low
    |=> pwr_out.ctrl_rst_n && pwr_out.ctrl_en)
    else $error("Control not released after reset hold");

  temp_stop_a: assert property (
    clk_en && cmp.temp_over |=> !pwr_out.operating && !pwr_out.dcdc_en)
    else $error("Operation continued above temperature threshold");

  temp_resume_a: assert property (
    state_reg == ST_OVERTEMP && clk_en && cmp.temp_clear && !cmp.temp_over
    && !cmp.sys_below_high && !cmp.sys_below_low
    |=> pwr_out.operating && pwr_out.dcdc_en)
    else $error("Operation did not resume after cooling");

  temp_hyst_a: assert property (
    state_reg == ST_OVERTEMP && clk_en && !cmp.temp_clear && !cmp.sys_below_low
    |=> state_reg == ST_OVERTEMP && !pwr_out.operating)
    else $error("Overtemperature released inside hysteresis band");

  sync_freeze_a: assert property (
    !clk_en
    |=> $stable(sync1_reg) && $stable(sync2_reg))
    else $error("Synchroniser moved while clock enable was low");

  state_freeze_a: assert property (
    !clk_en
    |=> $stable(state_reg) && $stable(cnt_reg) && $stable(pwr_out))
    else $error("State moved while clock enable was low");

  supply_split_a: assert property (
    clk_en && cmp.sys_below_high && !cmp.sys_below_low
    |=> pwr_out.ldo_en && !pwr_out.dcdc_en)
    else $error("Thresholds do not act on separate supply groups");

  dcdc_needs_good_a: assert property (
    pwr_out.dcdc_en
    |-> pwr_out.system_supply_good && pwr_out.ldo_en)
    else $error("Converters on without supply good");

  low_supply_a: assert property (
    state_reg == ST_RUN && clk_en && cmp.sys_below_high
    && !cmp.sys_below_low && !cmp.temp_over
    |=> state_reg == ST_LOW_SUPPLY && pwr_out.ctrl_en && pwr_out.ldo_en)
    else $error("Control stopped between the two thresholds");

  off_hold_a: assert property (
    state_reg == ST_OFF && clk_en && cmp.sys_below_low
    |=> state_reg == ST_OFF && pwr_out == PWR_RST)
    else $error("Outputs not all off below the lower threshold");

  ctrl_hold_a: assert property (
    state_reg == ST_CTRL_RESET && cnt_reg != RST_CNT_LAST
    && clk_en && !cmp.sys_below_low
    |=> state_reg == ST_CTRL_RESET && !pwr_out.ctrl_rst_n
    && cnt_reg == $past(cnt_reg) + RST_CNT_W'(1))
    else $error("Control reset hold cut short");

  cnt_bound_a: assert property (
    state_reg == ST_CTRL_RESET
    |-> cnt_reg <= RST_CNT_LAST)
    else $error("Control reset counter out of range");

  good_resume_a: assert property (
    state_reg == ST_LOW_SUPPLY && clk_en && !cmp.sys_below_high
    && !cmp.sys_below_low && !cmp.temp_over
    |=> pwr_out.system_supply_good && pwr_out.dcdc_en)
    else $error("Supply good or converters missing above the higher threshold");

  overtemp_enter_a: assert property (
    (state_reg == ST_RUN || state_reg == ST_LOW_SUPPLY) && clk_en
    && cmp.temp_over && !cmp.sys_below_low
    |=> state_reg == ST_OVERTEMP && pwr_out.ldo_en && !pwr_out.ctrl_en)
    else $error("Overtemperature stop did not keep regulators only");

  run_needs_ctrl_a: assert property (
    pwr_out.operating
    |-> pwr_out.ctrl_en && pwr_out.ctrl_rst_n && pwr_out.dcdc_en)
    else $error("Operating without control running");

endmodule // supply_and_thermal_protection

// ### shared/protect_pkg.sv
package protect_pkg;

  // Raw comparator levels, all active high
  typedef struct packed {
    logic sys_below_low;   // Supply under the lower undervoltage threshold
    logic sys_below_high;  // Supply under the higher undervoltage threshold
    logic temp_over;       // Die temperature above the overtemperature threshold
    logic temp_clear;      // Die temperature below threshold minus hysteresis
  } cmp_s;

  // Enables toward the power stage and the control core
  typedef struct packed {
    logic ldo_en;              // Always-on linear regulators
    logic dcdc_en;             // All step-down converters
    logic ctrl_en;             // Internal control circuit running
    logic ctrl_rst_n;          // Internal control circuit reset, active low
    logic system_supply_good;  // Supply above the higher threshold
    logic operating;           // Device in normal operation
  } pwr_s;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_CTRL_RESET,
    ST_LOW_SUPPLY,
    ST_RUN,
    ST_OVERTEMP
  } seq_state_e;

  localparam int unsigned CMP_W = $bits(cmp_s);

  // Synchroniser reset value: assume supply low and temperature cool
  localparam cmp_s CMP_RST = '{sys_below_low: 1'b1, sys_below_high: 1'b1,
                               temp_over: 1'b0, temp_clear: 1'b1};

  localparam pwr_s PWR_RST = '{default: 1'b0};

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned CTRL_RST_NS     = 1000;
  // Least time, rounded up to whole cycles
  localparam int unsigned CTRL_RST_CYCLES =
    (CTRL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W = $clog2(CTRL_RST_CYCLES + 1);
  localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = RST_CNT_W'(CTRL_RST_CYCLES - 1);
  localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = '0;

endpackage

// ### test/cmp_model.sv
module cmp_model (
  input  wire logic [1:0]   sup_lvl,
  input  wire logic [1:0]   temp_lvl,
  output protect_pkg::cmp_s cmp
);
  timeunit 1ns;
  timeprecision 100ps;
  import protect_pkg::*;
  // Supply 0: under both thresholds, 1: between them, 2: above both
  always_comb begin
    cmp.sys_below_low  = (sup_lvl == 2'h0);
    cmp.sys_below_high = (sup_lvl != 2'h2);
    // Level 1 sets neither temperature output, so only hysteresis decides
    cmp.temp_over      = (temp_lvl == 2'h2);
    cmp.temp_clear     = (temp_lvl == 2'h0);
  end
endmodule // cmp_model

// ### test/tb.sv
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import protect_pkg::*;
  logic        mclk, nrst, clk_en;
  logic [1:0]  sup_lvl, temp_lvl;
  cmp_s        cmp_in;
  pwr_s        pwr_out;
  logic [31:0] lfsr = 32'h4F8CAB4D;
  logic [5:0]  exp_q[$], msk_q[$], last = 6'h00;
  int          due_q[$], cyc = 0, bad_count = 0, check_count = 0, f;

  supply_and_thermal_protection dut (.mclk(mclk), .nrst(nrst), .clk_en(clk_en),
                                     .cmp_in(cmp_in), .pwr_out(pwr_out));
  cmp_model model (.sup_lvl(sup_lvl), .temp_lvl(temp_lvl), .cmp(cmp_in));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // Next value of the bench's random source
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task give_verdict;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Offset 4: three enabled edges of latency plus the pending cycle count update
  task note(int d, logic [5:0] m, logic [5:0] v);
    due_q.push_back(cyc + d);
    msk_q.push_back(m);
    exp_q.push_back(v);
  endtask
  task apply(logic [1:0] s, logic [1:0] t);
    @(posedge mclk);
    sup_lvl  <= s;
    temp_lvl <= t;
  endtask
  task step(int n);
    repeat (n) @(posedge mclk);
  endtask

  // Any change of the outputs must match the oldest note, at the noted cycle
  always @(negedge mclk) if (nrst && pwr_out !== last) begin
    if (exp_q.size() == 0) `CHK("unexpected change", last, pwr_out)
    else begin
      `CHK("pwr_out", exp_q[0] & msk_q[0], pwr_out & msk_q[0])
      `CHK("change cycle", due_q[0], cyc)
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
      void'(due_q.pop_front());
    end
    last = pwr_out;
  end

  initial begin
    #10000;
    bad_count++;
    give_verdict;
  end

  initial begin
    nrst     <= 1'b0;
    clk_en   <= 1'b1;
    sup_lvl  <= 2'h0;
    temp_lvl <= 2'h0;
    step(10);
    `CHK("reset out", PWR_RST, pwr_out)
    nrst <= 1'b1;
    step(5);
    lfsr = lfsr_next(lfsr);
    f = int'(lfsr[3:0]) + 1;
    apply(2'h2, 2'h0);
    note(4, 6'h3F, 6'h22);
    note(104 + f, 6'h3F, 6'h2E);
    note(105 + f, 6'h3F, 6'h3F);
    // Freezing mid count must stretch the control reset by exactly f cycles
    step(10);
    clk_en <= 1'b0;
    step(f);
    clk_en <= 1'b1;
    step(110);
    apply(2'h2, 2'h2);
    note(4, 6'h3F, 6'h26);
    step(20);
    apply(2'h2, 2'h1);
    step(30);
    apply(2'h2, 2'h0);
    note(4, 6'h3F, 6'h3F);
    step(20);
    apply(2'h1, 2'h0);
    note(4, 6'h3F, 6'h2C);
    step(20);
    apply(2'h0, 2'h0);
    note(4, 6'h3F, 6'h00);
    step(20);
    apply(2'h2, 2'h0);
    note(4, 6'h3F, 6'h22);
    note(104, 6'h3F, 6'h2E);
    note(105, 6'h3F, 6'h3F);
    step(120);
    // Supply lost from normal operation, then again while the control reset is still held
    apply(2'h0, 2'h0);
    note(4, 6'h3F, 6'h00);
    step(20);
    apply(2'h2, 2'h0);
    note(4, 6'h3F, 6'h22);
    step(30);
    apply(2'h0, 2'h0);
    note(4, 6'h3F, 6'h00);
    step(20);
    `CHK("notes left", 0, exp_q.size())
    give_verdict;
  end
endmodule // tb
